// ---- logic/arts_pkg.sv ----
// package for the auto-reload timer with capture: register map, field
// positions, reset values and the shared bus structs.
// assumes a single core clock domain; the core drives the register port.
package arts_pkg;

    // ========================================================================
    // register offsets on the special-function register port
    localparam logic [7:0] ARTS_ADDR_CTRL = 8'h91;
    localparam logic [7:0] ARTS_ADDR_RLD_LO = 8'h92;
    localparam logic [7:0] ARTS_ADDR_RLD_HI = 8'h93;
    localparam logic [7:0] ARTS_ADDR_CNT_LO = 8'h94;
    localparam logic [7:0] ARTS_ADDR_CNT_HI = 8'h95;

    // ========================================================================
    // control register field positions
    localparam int ARTS_BIT_HOVF = 7;
    localparam int ARTS_BIT_LOVF = 6;
    localparam int ARTS_BIT_LIEN = 5;
    localparam int ARTS_BIT_CAPEN = 4;
    localparam int ARTS_BIT_SPLIT = 3;
    localparam int ARTS_BIT_RUN = 2;
    localparam int ARTS_BIT_CAPSRC = 1;
    localparam int ARTS_BIT_XCLK = 0;

    // ========================================================================
    // reset values
    localparam logic [7:0] ARTS_RST_CTRL = 8'h00;
    localparam logic [7:0] ARTS_RST_BYTE = 8'h00;

    // ========================================================================
    // timing counts
    localparam int ARTS_DIV_SYS = 12;
    localparam int ARTS_DIV_OSC = 8;
    localparam int ARTS_CAP_EDGES = 8;
    localparam logic [7:0] ARTS_BYTE_MAX = 8'hFF;

    // register port request bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arts_req_t;

    // clock-select straps from the clock configuration register
    typedef struct packed {
        logic high_byte_fast_clock_select;
        logic low_byte_fast_clock_select;
    } arts_clksel_t;

endpackage

// ---- logic/arts_edge_sync.sv ----
// two-flop synchroniser plus rising-edge pulse for one slow clock.
// assumes the input is an unrelated oscillator divided down in its own domain.
`timescale 1ns/1ps
module arts_edge_sync
    import arts_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic rise_pulse
);
    logic meta_q, meta_d, sync_q, sync_d, last_q, last_d;

    // ========================================================================
    // first flop feeds only the second one
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign rise_pulse = sync_q & ~last_q;
endmodule

// ---- logic/arts_timer.sv ----
// auto-reload timer with capture: 16-bit or split 8-bit counting, capture of
// the count on every eighth edge of an oscillator, register port for the core.
// assumes ext_osc_div8 and rtc_osc_div8 are slow square waves from other
// domains, and the core issues at most one read or write per cycle.
//
// How it works
// - 16-bit wrap reloads and sets high flag
// - control bit 3 picks split mode
// - 16-bit overflow requests interrupt when enabled
// - low-byte wrap interrupts if low enable set
// - split: each byte reloads its own byte
// - run gates all; split gates high only
// - per-byte fast select, else sys/12 or ext/8 or rtc/8
// - external divided clock synchronised before use
// - high and low wraps set their flags
// - split: high overflow, low too if enabled
// - flags cleared only by software writes
// - capture every 8 selected oscillator cycles
// - capture copies count to reload, sets flag
// - control bit 4 enables capture
// - capture source also picks counting oscillator
// - bit 0 selects sys/12 or oscillator
// - count bytes at 0x94/0x95, reset zero
`timescale 1ns/1ps
module arts_timer
    import arts_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire arts_req_t req,
    input wire arts_clksel_t clksel,
    input wire logic irq_enable,
    input wire logic ext_osc_div8,
    input wire logic rtc_osc_div8,
    output logic [7:0] rdata_q,
    output logic irq_q
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rld_lo_q, rld_lo_d, rld_hi_q, rld_hi_d;
    logic [7:0] cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
    logic [3:0] div12_q, div12_d;
    logic [2:0] cap_cnt_q, cap_cnt_d;
    logic [7:0] rdata_d;
    logic irq_d;
    logic ext_tick, rtc_tick, sys12_tick, osc_tick, cap_edge;
    logic tick_lo, tick_hi, run_lo, run_hi, split, wrap_lo, wrap_hi, cap_event;

    // ========================================================================
    // clock sources
    arts_edge_sync u_ext_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(ext_osc_div8),
        .rise_pulse(ext_tick)
    );
    arts_edge_sync u_rtc_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(rtc_osc_div8),
        .rise_pulse(rtc_tick)
    );

    // prescaler and tick selection per byte
    always_comb begin
        div12_d = (div12_q == 4'(ARTS_DIV_SYS - 1)) ? 4'h0 : div12_q + 4'h1;
        sys12_tick = (div12_q == 4'(ARTS_DIV_SYS - 1));
        // oscillator counted when bit 0 is set: capture source inverts it
        osc_tick = ctrl_q[ARTS_BIT_CAPSRC] ? rtc_tick : ext_tick;
        tick_lo = clksel.low_byte_fast_clock_select ? 1'b1 :
                  (ctrl_q[ARTS_BIT_XCLK] ? osc_tick : sys12_tick);
        tick_hi = clksel.high_byte_fast_clock_select ? 1'b1 :
                  (ctrl_q[ARTS_BIT_XCLK] ? osc_tick : sys12_tick);
    end

    // ========================================================================
    // capture divider: eighth edge of the chosen source oscillator
    always_comb begin
        cap_edge = ctrl_q[ARTS_BIT_CAPSRC] ? ext_tick : rtc_tick;
        cap_cnt_d = cap_cnt_q;
        cap_event = 1'b0;
        if (!ctrl_q[ARTS_BIT_CAPEN]) begin
            cap_cnt_d = 3'h0;
        end else if (cap_edge) begin
            cap_cnt_d = cap_cnt_q + 3'h1;
            cap_event = (cap_cnt_q == 3'(ARTS_CAP_EDGES - 1));
        end
    end

    // ========================================================================
    // counter, flags and register writes
    always_comb begin
        split = ctrl_q[ARTS_BIT_SPLIT];
        run_hi = ctrl_q[ARTS_BIT_RUN] & tick_hi;
        run_lo = split ? tick_lo : (ctrl_q[ARTS_BIT_RUN] & tick_lo);
        ctrl_d = ctrl_q;
        rld_lo_d = rld_lo_q;
        rld_hi_d = rld_hi_q;
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        wrap_lo = 1'b0;
        wrap_hi = 1'b0;
        // software writes first so hardware sets below win the same cycle
        if (req.wr) begin
            case (req.addr)
                ARTS_ADDR_CTRL: ctrl_d = req.wdata;
                ARTS_ADDR_RLD_LO: rld_lo_d = req.wdata;
                ARTS_ADDR_RLD_HI: rld_hi_d = req.wdata;
                ARTS_ADDR_CNT_LO: cnt_lo_d = req.wdata;
                ARTS_ADDR_CNT_HI: cnt_hi_d = req.wdata;
                default: ;
            endcase
        end else if (split) begin
            if (run_lo) begin
                wrap_lo = (cnt_lo_q == ARTS_BYTE_MAX);
                cnt_lo_d = wrap_lo ? rld_lo_q : cnt_lo_q + 8'h01;
            end
            if (run_hi) begin
                wrap_hi = (cnt_hi_q == ARTS_BYTE_MAX);
                cnt_hi_d = wrap_hi ? rld_hi_q : cnt_hi_q + 8'h01;
            end
        end else if (run_lo) begin
            // 16-bit mode: whole count advances on the low byte clock
            wrap_lo = (cnt_lo_q == ARTS_BYTE_MAX);
            wrap_hi = wrap_lo && (cnt_hi_q == ARTS_BYTE_MAX);
            if (wrap_hi) begin
                cnt_lo_d = rld_lo_q;
                cnt_hi_d = rld_hi_q;
            end else begin
                {cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
            end
        end
        if (cap_event) begin
            rld_lo_d = cnt_lo_q;
            rld_hi_d = cnt_hi_q;
        end
        if (wrap_hi || cap_event) begin
            ctrl_d[ARTS_BIT_HOVF] = 1'b1;
        end
        if (wrap_lo) begin
            ctrl_d[ARTS_BIT_LOVF] = 1'b1;
        end
    end

    // ========================================================================
    // read data and interrupt, both registered
    always_comb begin
        case (req.addr)
            ARTS_ADDR_CTRL: rdata_d = ctrl_q;
            ARTS_ADDR_RLD_LO: rdata_d = rld_lo_q;
            ARTS_ADDR_RLD_HI: rdata_d = rld_hi_q;
            ARTS_ADDR_CNT_LO: rdata_d = cnt_lo_q;
            ARTS_ADDR_CNT_HI: rdata_d = cnt_hi_q;
            default: rdata_d = 8'h00;
        endcase
        if (!req.rd) begin
            rdata_d = rdata_q;
        end
        // same rule in both modes: high always, low only with its enable
        irq_d = irq_enable & (ctrl_q[ARTS_BIT_HOVF] |
                (ctrl_q[ARTS_BIT_LIEN] & ctrl_q[ARTS_BIT_LOVF]));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ARTS_RST_CTRL;
            rld_lo_q <= ARTS_RST_BYTE;
            rld_hi_q <= ARTS_RST_BYTE;
            cnt_lo_q <= ARTS_RST_BYTE;
            cnt_hi_q <= ARTS_RST_BYTE;
            div12_q <= 4'h0;
            cap_cnt_q <= 3'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rld_lo_q <= rld_lo_d;
            rld_hi_q <= rld_hi_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            div12_q <= div12_d;
            cap_cnt_q <= cap_cnt_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // ========================================================================
    // checks
    sequence s_wrap16;
        !split && !req.wr && run_lo && cnt_lo_q == 8'hFF && cnt_hi_q == 8'hFF;
    endsequence

    a_wrap_reload: assert property (@(posedge clk) disable iff (!rst_n)
        s_wrap16 |=> cnt_lo_q == $past(rld_lo_q) && cnt_hi_q == $past(rld_hi_q)
            && ctrl_q[ARTS_BIT_HOVF])
        else $error("16-bit wrap did not reload");
    a_split_lo: assert property (@(posedge clk) disable iff (!rst_n)
        split && !req.wr && tick_lo && cnt_lo_q == 8'hFF && !cap_event
            |=> cnt_lo_q == $past(rld_lo_q) && ctrl_q[ARTS_BIT_LOVF])
        else $error("split low byte did not reload");
    a_run_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[ARTS_BIT_RUN] && !req.wr |=> $stable(cnt_hi_q))
        else $error("high byte moved while stopped");
    a_split_lo_free: assert property (@(posedge clk) disable iff (!rst_n)
        split && !req.wr && clksel.low_byte_fast_clock_select && cnt_lo_q != 8'hFF
            |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
        else $error("split low byte not free running");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[ARTS_BIT_HOVF] && !req.wr |=> ctrl_q[ARTS_BIT_HOVF])
        else $error("overflow flag cleared without a write");
    a_cap_copy: assert property (@(posedge clk) disable iff (!rst_n)
        cap_event |=> rld_lo_q == $past(cnt_lo_q) && rld_hi_q == $past(cnt_hi_q)
            && ctrl_q[ARTS_BIT_HOVF])
        else $error("capture did not copy count");
    a_cap_off: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[ARTS_BIT_CAPEN] && !req.wr |=> $stable(rld_lo_q) && $stable(rld_hi_q))
        else $error("reload changed while capture disabled");
    a_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
        irq_enable && ctrl_q[ARTS_BIT_HOVF] |=> irq_q)
        else $error("interrupt missing for set high flag");

    // ========================================================================
    // further checks: flags, interrupt masking, register port, clock sources
    // the whole-count step is a sequence so the two 16-bit step checks share it
    sequence s_step16;
        !split && !req.wr && run_lo;
    endsequence

    sequence s_lo_top;
        cnt_lo_q == ARTS_BYTE_MAX;
    endsequence

    // low flag follows a low-byte wrap in 16-bit mode too
    a_lo_flag16: assert property (@(posedge clk) disable iff (!rst_n)
        s_step16 ##0 s_lo_top |=> ctrl_q[ARTS_BIT_LOVF])
        else $error("low flag missing after 16-bit low wrap");

    // plain 16-bit step carries from the low byte into the high byte
    a_count16: assert property (@(posedge clk) disable iff (!rst_n)
        s_step16 ##0 !(cnt_lo_q == 8'hFF && cnt_hi_q == 8'hFF)
            |=> {cnt_hi_q, cnt_lo_q} == $past({cnt_hi_q, cnt_lo_q}) + 16'h0001)
        else $error("16-bit count did not step by one");

    // stopped 16-bit timer leaves the low byte alone as well
    a_stop16: assert property (@(posedge clk) disable iff (!rst_n)
        !split && !ctrl_q[ARTS_BIT_RUN] && !req.wr |=> $stable(cnt_lo_q))
        else $error("low byte moved while 16-bit timer stopped");

    // split high byte reloads from its own reload byte
    a_split_hi: assert property (@(posedge clk) disable iff (!rst_n)
        split && !req.wr && run_hi && cnt_hi_q == 8'hFF
            |=> cnt_hi_q == $past(rld_hi_q) && ctrl_q[ARTS_BIT_HOVF])
        else $error("split high byte did not reload");

    // split high byte only moves on its own gated tick
    a_split_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        split && !run_hi && !req.wr |=> $stable(cnt_hi_q))
        else $error("split high byte moved without its tick");

    // low flag reaches the request line once its enable is set
    a_irq_low: assert property (@(posedge clk) disable iff (!rst_n)
        irq_enable && ctrl_q[ARTS_BIT_LIEN] && ctrl_q[ARTS_BIT_LOVF] |=> irq_q)
        else $error("interrupt missing for enabled low flag");

    // masked timer, or one with no high flag and no low enable, keeps the request line low
    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_enable || (!ctrl_q[ARTS_BIT_HOVF] && !ctrl_q[ARTS_BIT_LIEN]) |=> !irq_q)
        else $error("interrupt raised with nothing enabled");

    // the low flag is as sticky as the high one
    a_lo_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[ARTS_BIT_LOVF] && !req.wr |=> ctrl_q[ARTS_BIT_LOVF])
        else $error("low flag cleared without a write");

    // register port: a write lands next cycle, a read shows the old value
    a_cnt_write: assert property (@(posedge clk) disable iff (!rst_n)
        req.wr && req.addr == ARTS_ADDR_CNT_HI |=> cnt_hi_q == $past(req.wdata))
        else $error("count high write did not land");
    a_cnt_read: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == ARTS_ADDR_CNT_LO |=> rdata_q == $past(cnt_lo_q))
        else $error("count low read returned wrong data");

    // divide-by-12 prescaler: one tick, then eleven quiet cycles
    sequence s_quiet11;
        !sys12_tick [*8] ##1 !sys12_tick [*3];
    endsequence

    a_sys12_gap: assert property (@(posedge clk) disable iff (!rst_n)
        sys12_tick |=> s_quiet11 ##1 sys12_tick)
        else $error("prescaler tick spacing wrong");

    // oscillator edges reach the count logic two edges after sampling
    a_ext_sync: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ext_osc_div8) |-> ##2 ext_tick)
        else $error("external oscillator edge not synchronised");

    // capture source 0 counts the external oscillator, so no tick, no step
    a_osc_pick: assert property (@(posedge clk) disable iff (!rst_n)
        !split && !req.wr && ctrl_q[ARTS_BIT_XCLK] && !ctrl_q[ARTS_BIT_CAPSRC]
            && !clksel.low_byte_fast_clock_select && !ext_tick |=> $stable(cnt_lo_q))
        else $error("count moved without an external oscillator tick");

    // capture divider ignores the oscillator it is not measuring
    a_cap_src: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[ARTS_BIT_CAPEN] && !ctrl_q[ARTS_BIT_CAPSRC] && !rtc_tick
            |=> $stable(cap_cnt_q))
        else $error("capture count moved on the wrong source");
endmodule

// ---- test/arts_osc_model.sv ----
// oscillator sources seen by the timer: external and rtc, already /8.
// assumes the core clock is unrelated; edges are offset from it on purpose.
`timescale 1ns/1ps
module arts_osc_model #(
    parameter int EXT_HALF_NS = 20,
    parameter int RTC_HALF_NS = 12
) (
    output logic ext_osc_div8,
    output logic rtc_osc_div8
);
    // ========================================================================
    // free-running square waves; odd offsets keep edges off clk edges
    initial begin
        ext_osc_div8 = 1'b0;
        #1.3;
        forever #(EXT_HALF_NS) ext_osc_div8 = ~ext_osc_div8;
    end
    initial begin
        rtc_osc_div8 = 1'b0;
        #0.7;
        forever #(RTC_HALF_NS) rtc_osc_div8 = ~rtc_osc_div8;
    end
endmodule

// ---- test/arts_timer_tb.sv ----
// self-checking bench for the auto-reload timer with capture.
// assumes arts_pkg is compiled first; inputs change on falling clk edges.
`timescale 1ns/1ps
module arts_timer_tb
    import arts_pkg::*;
;
    localparam int EXT_P = 10;
    localparam int RTC_P = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    arts_req_t req = '0;
    arts_clksel_t clksel = '0;
    logic irq_enable = 1'b0;
    logic ext_osc_div8;
    logic rtc_osc_div8;
    logic [7:0] rdata_q;
    logic irq_q;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] v;
    logic [7:0] h;
    logic [15:0] cap [2];
    logic [7:0] ctl [3] = '{8'h04, 8'h05, 8'h07};
    int per [3] = '{12, EXT_P, RTC_P};

    always #2 clk = ~clk;

    arts_osc_model #(.EXT_HALF_NS(EXT_P * 2), .RTC_HALF_NS(RTC_P * 2)) arts_osc_model_inst (
        .ext_osc_div8(ext_osc_div8), .rtc_osc_div8(rtc_osc_div8));
    arts_timer arts_timer_inst (.clk(clk), .rst_n(rst_n), .req(req), .clksel(clksel),
        .irq_enable(irq_enable), .ext_osc_div8(ext_osc_div8), .rtc_osc_div8(rtc_osc_div8),
        .rdata_q(rdata_q), .irq_q(irq_q));

    // ========================================================================
    // shared tasks: compare, register write and read, verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // request held across one rising edge, released at the next falling one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        d = rdata_q;
    endtask
    task automatic print_verdict();
        $display("compared %0d, unexpected %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far above the several hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("unexpected at %0t: timeout", $time);
            n_mismatch++;
            print_verdict();
        end
    end

    // ========================================================================
    // main sequence
    initial begin
        void'($urandom(32'h2aba));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        // reset values, unmapped neighbours read zero
        for (int a = 8'h90; a <= 8'h96; a++) begin
            rd(8'(a), v);
            chk(16'(v), 16'h0000, "reset value");
        end
        for (int i = 0; i < 4; i++) begin
            h = 8'($urandom);
            wr(ARTS_ADDR_RLD_LO + 8'(i % 2), h);
            rd(ARTS_ADDR_RLD_LO + 8'(i % 2), v);
            chk(16'(v), 16'(h), "reload rw");
        end
        $display("test registers done");
        // 16-bit wrap with random reload high byte
        irq_enable = 1'b1;
        clksel = '{high_byte_fast_clock_select: 1'b0, low_byte_fast_clock_select: 1'b1};
        h = 8'($urandom_range(8'h7F, 8'h10));
        wr(ARTS_ADDR_RLD_HI, h);
        wr(ARTS_ADDR_RLD_LO, 8'h00);
        wr(ARTS_ADDR_CNT_HI, 8'hFF);
        wr(ARTS_ADDR_CNT_LO, 8'hF0);
        wr(ARTS_ADDR_CTRL, 8'h04);
        repeat (40) @(negedge clk);
        chk(16'(irq_q), 16'h0001, "irq on wrap");
        rd(ARTS_ADDR_CNT_HI, v);
        chk(16'(v), 16'(h), "reload on wrap");
        repeat (50) @(negedge clk);
        rd(ARTS_ADDR_CTRL, v);
        chk(16'(v), 16'h00C4, "flags stay set");
        irq_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(irq_q), 16'h0000, "irq masked");
        irq_enable = 1'b1;
        wr(ARTS_ADDR_CTRL, 8'h00);
        repeat (2) @(negedge clk);
        chk(16'(irq_q), 16'h0000, "irq after clear");
        $display("test 16-bit done");
        // split: low byte free-running, high byte stopped until run is set for its wrap
        clksel = '{high_byte_fast_clock_select: 1'b1, low_byte_fast_clock_select: 1'b1};
        wr(ARTS_ADDR_RLD_LO, 8'hF0);
        wr(ARTS_ADDR_CNT_LO, 8'hF0);
        wr(ARTS_ADDR_CNT_HI, 8'h77);
        wr(ARTS_ADDR_CTRL, 8'h08);
        repeat (40) @(negedge clk);
        rd(ARTS_ADDR_CNT_HI, v);
        chk(16'(v), 16'h0077, "high held");
        chk(16'(irq_q), 16'h0000, "no low irq");
        rd(ARTS_ADDR_CNT_LO, v);
        chk(16'(v >= 8'hF0), 16'h0001, "low reload");
        rd(ARTS_ADDR_CTRL, v);
        chk(16'(v), 16'h0048, "low flag only");
        wr(ARTS_ADDR_CTRL, 8'h28);
        repeat (20) @(negedge clk);
        chk(16'(irq_q), 16'h0001, "low irq");
        wr(ARTS_ADDR_CTRL, 8'h00);
        wr(ARTS_ADDR_CNT_HI, 8'hFE);
        wr(ARTS_ADDR_CTRL, 8'h0C);
        repeat (10) @(negedge clk);
        rd(ARTS_ADDR_CTRL, v);
        chk(16'(v[7]), 16'h0001, "high flag");
        chk(16'(irq_q), 16'h0001, "high irq");
        $display("test split done");
        // count clock selects: sys/12, ext/8, rtc/8, ten periods each
        clksel = '0;
        for (int k = 0; k < 3; k++) begin
            wr(ARTS_ADDR_CTRL, 8'h00);
            wr(ARTS_ADDR_CNT_HI, 8'h00);
            wr(ARTS_ADDR_CNT_LO, 8'h00);
            wr(ARTS_ADDR_CTRL, ctl[k]);
            repeat (10 * per[k]) @(negedge clk);
            rd(ARTS_ADDR_CNT_LO, v);
            chk(16'(v >= 8'h09 && v <= 8'h0B), 16'h0001, "clock select");
        end
        $display("test clock select done");
        // capture: spacing of two captures, minus the one clearing write
        clksel = '{high_byte_fast_clock_select: 1'b0, low_byte_fast_clock_select: 1'b1};
        for (int s = 0; s < 2; s++) begin
            for (int n = 0; n < 2; n++) begin
                wr(ARTS_ADDR_CTRL, 8'h14 | 8'(s << 1));
                v = 8'h00;
                for (int t = 0; t < 200 && !v[7]; t++) begin
                    rd(ARTS_ADDR_CTRL, v);
                end
                rd(ARTS_ADDR_RLD_LO, cap[n][7:0]);
                rd(ARTS_ADDR_RLD_HI, cap[n][15:8]);
            end
            chk(cap[1] - cap[0], 16'(8 * (s ? EXT_P : RTC_P) - 1), "capture");
        end
        $display("test capture done");
        print_verdict();
    end
endmodule
